//--- logic/bhx_expand_unit.sv
// Execute-stage datapath for the byte-to-halfword expand instruction group
//
// Operation
// - Match opcode, zero field and function code
// - Selector 00101/00111 choose fractional expands
// - Selector 11100/11110/11101 choose unsigned expands
// - Source register in, destination register out
// - Fractional: zero, byte, seven zeros
// - Fractional right pair: bytes 1, 0
// - Fractional right alternate: bytes 2, 0
// - Unsigned: eight zeros above the byte
// - Unsigned left pair: bytes 3, 2
// - Unsigned left alternate: bytes 3, 1
// - Unsigned right pair: bytes 1, 0
// - Pack halfwords, sign-extend bit 31
// - No operand-dependent exceptions ever
// - Reserved or disabled exception instead of executing
`timescale 1ns/1ps
module bhx_expand_unit (
   input wire logic clk_i, // 200 MHz core clock
   input wire logic reset_n_i, // Synchronous reset, active low
   input wire bhx_pkg::bhx_req_t req_i, // Issued instruction and operand
   output logic [4:0] src_reg_o, // Register file read index
   output bhx_pkg::bhx_rsp_t rsp_o // Registered write-back and exceptions
);

   // ****************************************
   // Decode
   // ****************************************
   logic [4:0] sub_sel;
   logic group_hit;
   logic sel_known;
   logic frac_mode;
   logic [7:0] upper_byte;
   logic [7:0] lower_byte;
   logic [15:0] upper_half;
   logic [15:0] lower_half;
   logic [31:0] packed_word;
   logic [4:0] next_src_reg;
   bhx_pkg::bhx_rsp_t next_rsp;
   bhx_pkg::bhx_rsp_t rsp;
   logic [4:0] src_reg;

   assign sub_sel = req_i.instr[bhx_pkg::SUB_HI:bhx_pkg::SUB_LO];

   always_comb begin
      group_hit = (req_i.instr[bhx_pkg::OPC_HI:bhx_pkg::OPC_LO] == bhx_pkg::SPECIAL_THREE_OPCODE)
         && (req_i.instr[bhx_pkg::ZERO_HI:bhx_pkg::ZERO_LO] == bhx_pkg::ZERO_FIELD)
         && (req_i.instr[bhx_pkg::FN_HI:bhx_pkg::FN_LO] == bhx_pkg::EXPAND_GROUP_FUNCTION_CODE);
      sel_known = 1'b1;
      frac_mode = 1'b0;
      upper_byte = 8'h00;
      lower_byte = 8'h00;
      // Only the low word of the source is read; upper bits are ignored
      unique case (sub_sel)
         bhx_pkg::FRAC_EXPAND_RIGHT_PAIR: begin
            frac_mode = 1'b1;
            upper_byte = req_i.src_data[bhx_pkg::BYTE1_LO +: 8];
            lower_byte = req_i.src_data[bhx_pkg::BYTE0_LO +: 8];
         end
         bhx_pkg::FRAC_EXPAND_RIGHT_ALTERNATE: begin
            frac_mode = 1'b1;
            upper_byte = req_i.src_data[bhx_pkg::BYTE2_LO +: 8];
            lower_byte = req_i.src_data[bhx_pkg::BYTE0_LO +: 8];
         end
         bhx_pkg::UNSIGNED_EXPAND_LEFT_PAIR: begin
            upper_byte = req_i.src_data[bhx_pkg::BYTE3_LO +: 8];
            lower_byte = req_i.src_data[bhx_pkg::BYTE2_LO +: 8];
         end
         bhx_pkg::UNSIGNED_EXPAND_LEFT_ALTERNATE: begin
            upper_byte = req_i.src_data[bhx_pkg::BYTE3_LO +: 8];
            lower_byte = req_i.src_data[bhx_pkg::BYTE1_LO +: 8];
         end
         bhx_pkg::UNSIGNED_EXPAND_RIGHT_PAIR: begin
            upper_byte = req_i.src_data[bhx_pkg::BYTE1_LO +: 8];
            lower_byte = req_i.src_data[bhx_pkg::BYTE0_LO +: 8];
         end
         default: begin
            // Other selectors belong to neighbouring instructions
            sel_known = 1'b0;
         end
      endcase
   end

   // ****************************************
   // Widening lanes
   // ****************************************
   bhx_widen u_widen_upper (
      .byte_i(upper_byte),
      .frac_i(frac_mode),
      .half_o(upper_half)
   );

   bhx_widen u_widen_lower (
      .byte_i(lower_byte),
      .frac_i(frac_mode),
      .half_o(lower_half)
   );

   assign packed_word = {upper_half, lower_half};

   // ****************************************
   // Write-back and exceptions
   // ****************************************
   always_comb begin
      next_src_reg = req_i.instr[bhx_pkg::SRC_HI:bhx_pkg::SRC_LO];
      next_rsp = '0;
      next_rsp.wb_reg = req_i.instr[bhx_pkg::DST_HI:bhx_pkg::DST_LO];
      next_rsp.wb_data = {{32{packed_word[31]}}, packed_word};
      if (req_i.valid && group_hit && sel_known) begin
         // Exceptions depend on extension state only, never on data
         if (!req_i.ext_present) begin
            next_rsp.exc_reserved = 1'b1;
         end else if (!req_i.ext_enabled) begin
            next_rsp.exc_disabled = 1'b1;
         end else begin
            next_rsp.wb_en = 1'b1;
         end
      end
   end

   // Result registered once so the write-back port sees a flop
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rsp <= '{wb_en: 1'b0, wb_reg: bhx_pkg::REG_RESET, wb_data: bhx_pkg::RESULT_RESET,
                  exc_reserved: 1'b0, exc_disabled: 1'b0};
         src_reg <= bhx_pkg::REG_RESET;
      end else begin
         rsp <= next_rsp;
         src_reg <= next_src_reg;
      end
   end

   assign rsp_o = rsp;
   assign src_reg_o = src_reg;

endmodule : bhx_expand_unit

//--- logic/bhx_pkg.sv
// Package of constants and carrier types for the byte-to-halfword expand unit
package bhx_pkg;

   // ****************************************
   // Instruction fields
   // ****************************************
   localparam int OPC_HI = 31;
   localparam int OPC_LO = 26;
   localparam int ZERO_HI = 25;
   localparam int ZERO_LO = 21;
   localparam int SRC_HI = 20;
   localparam int SRC_LO = 16;
   localparam int DST_HI = 15;
   localparam int DST_LO = 11;
   localparam int SUB_HI = 10;
   localparam int SUB_LO = 6;
   localparam int FN_HI = 5;
   localparam int FN_LO = 0;

   localparam logic [5:0] SPECIAL_THREE_OPCODE = 6'h1F;
   localparam logic [4:0] ZERO_FIELD = 5'h00;
   localparam logic [5:0] EXPAND_GROUP_FUNCTION_CODE = 6'h12;

   // ****************************************
   // Sub-operation selector codes
   // ****************************************
   typedef enum logic [4:0] {
      FRAC_EXPAND_RIGHT_PAIR = 5'b00101,
      FRAC_EXPAND_RIGHT_ALTERNATE = 5'b00111,
      UNSIGNED_EXPAND_LEFT_PAIR = 5'b11100,
      UNSIGNED_EXPAND_LEFT_ALTERNATE = 5'b11110,
      UNSIGNED_EXPAND_RIGHT_PAIR = 5'b11101
   } bhx_subop_t;

   // Byte lane positions within the source low word
   localparam int BYTE0_LO = 0;
   localparam int BYTE1_LO = 8;
   localparam int BYTE2_LO = 16;
   localparam int BYTE3_LO = 24;
   localparam int FRAC_PAD = 7;
   localparam logic [63:0] RESULT_RESET = 64'h0000_0000_0000_0000;
   localparam logic [4:0] REG_RESET = 5'h00;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic valid;
      logic [31:0] instr;
      logic [63:0] src_data;
      logic ext_present;
      logic ext_enabled;
   } bhx_req_t;

   typedef struct packed {
      logic wb_en;
      logic [4:0] wb_reg;
      logic [63:0] wb_data;
      logic exc_reserved;
      logic exc_disabled;
   } bhx_rsp_t;

endpackage : bhx_pkg

//--- logic/bhx_widen.sv
// Widens one source byte to a halfword, fractional or unsigned form
`timescale 1ns/1ps
module bhx_widen (
   input wire logic [7:0] byte_i, // Source byte
   input wire logic frac_i, // High: Q15 form, low: unsigned form
   output logic [15:0] half_o // Widened halfword
);

   always_comb begin
      if (frac_i) begin
         half_o = {1'b0, byte_i, {bhx_pkg::FRAC_PAD{1'b0}}};
      end else begin
         half_o = {8'h00, byte_i};
      end
   end

endmodule : bhx_widen

//--- tb/bhx_expand_unit_assertions.sv
// Port checker of the expand unit
`timescale 1ns/1ps
module bhx_expand_unit_assertions (
   input wire logic clk_i, // Clock
   input wire logic reset_n_i, // Reset
   input wire bhx_pkg::bhx_req_t req_i, // Request
   input wire logic [4:0] src_reg_o, // Read index
   input wire bhx_pkg::bhx_rsp_t rsp_o // Answer
);
   logic dec;
   logic ok;
   logic [4:0] s;
   logic [31:0] x;
   logic [31:0] d;
   assign s = req_i.instr[10:6];
   assign x = req_i.src_data[31:0];
   assign d = rsp_o.wb_data[31:0];
   assign dec = req_i.valid && req_i.instr[31:21] == 11'h3E0 && req_i.instr[5:0] == 6'h12 &&
      s inside {5'h05, 5'h07, 5'h1C, 5'h1D, 5'h1E};
   assign ok = dec && req_i.ext_present && req_i.ext_enabled;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   decode_refuse_a: assert property (!dec |=> !rsp_o.wb_en && !rsp_o.exc_reserved && !rsp_o.exc_disabled)
      else $error("answered");
   reserved_exc_a: assert property (dec && !req_i.ext_present |=> rsp_o.exc_reserved && !rsp_o.wb_en)
      else $error("reserved");
   disabled_exc_a: assert property (dec && req_i.ext_present && !req_i.ext_enabled |=>
      rsp_o.exc_disabled && !rsp_o.wb_en) else $error("disabled");
   write_back_a: assert property (ok |=> rsp_o.wb_en &&
      rsp_o.wb_reg == $past(req_i.instr[15:11]) && rsp_o.wb_data[63:32] == 32'h0) else $error("wb");
   frac_right_a: assert property (ok && s == 5'h05 |=>
      d == {1'b0, $past(x[15:8]), 8'h00, $past(x[7:0]), 7'h00}) else $error("frac");
   frac_alt_a: assert property (ok && s == 5'h07 |=>
      d == {1'b0, $past(x[23:16]), 8'h00, $past(x[7:0]), 7'h00}) else $error("frac alt");
   uns_left_a: assert property (ok && s == 5'h1C |=>
      d == {8'h00, $past(x[31:24]), 8'h00, $past(x[23:16])}) else $error("left");
   uns_right_a: assert property (ok && s == 5'h1D |=>
      d == {8'h00, $past(x[15:8]), 8'h00, $past(x[7:0])}) else $error("right");
   uns_left_alt_a: assert property (ok && s == 5'h1E |=>
      d == {8'h00, $past(x[31:24]), 8'h00, $past(x[15:8])}) else $error("left alt");
   src_index_a: assert property (1'b1 |=> src_reg_o == $past(req_i.instr[20:16]))
      else $error("source index");
endmodule : bhx_expand_unit_assertions
bind bhx_expand_unit bhx_expand_unit_assertions chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req_i),
   .src_reg_o(src_reg_o), .rsp_o(rsp_o));

//--- tb/bhx_regfile_model.sv
// Register file model feeding the source operand
`timescale 1ns/1ps
module bhx_regfile_model (
   input wire logic [31:0] instr_i, // Issued instruction
   output logic [63:0] data_o // Source register value
);
   // High word all ones so a leak into the result shows
   assign data_o = {32'hFFFF_FFFF, 32'h8C4E_A217 + {4{3'h0, instr_i[20:16]}}};
endmodule : bhx_regfile_model

//--- tb/testbench.sv
// Self-checking bench of the expand unit
`timescale 1ns/1ps
module testbench;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic v = 1'b0;
   logic ep = 1'b1;
   logic ee = 1'b1;
   logic [31:0] ins = 32'h0;
   logic [63:0] sd;
   logic [4:0] sr;
   bhx_pkg::bhx_req_t req;
   bhx_pkg::bhx_rsp_t rsp;
   int err_count = 0;
   int num_checks = 0;
   always #2.5 clk_i = ~clk_i;
   assign req = '{v, ins, sd, ep, ee};
   bhx_regfile_model rf_u (.instr_i(ins), .data_o(sd));
   bhx_expand_unit dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req), .src_reg_o(sr), .rsp_o(rsp));
   function automatic logic [63:0] expv(input logic [4:0] op, input logic [4:0] rs);
      logic [31:0] x;
      logic [31:0] r;
      x = 32'h8C4E_A217 + {4{3'h0, rs}};
      case (op)
         5'h05: r = {1'b0, x[15:8], 8'h00, x[7:0], 7'h00};
         5'h07: r = {1'b0, x[23:16], 8'h00, x[7:0], 7'h00};
         5'h1C: r = {8'h00, x[31:24], 8'h00, x[23:16]};
         5'h1E: r = {8'h00, x[31:24], 8'h00, x[15:8]};
         default: r = {8'h00, x[15:8], 8'h00, x[7:0]};
      endcase
      return {{32{r[31]}}, r};
   endfunction : expv
   task cmp(input logic [71:0] got, input logic [71:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %0t %h %h", $time, got, exp);
      end
   endtask : cmp
   // Flags: valid, present, enabled; answer sampled after the taking edge
   task issue(input logic [4:0] op, input logic [4:0] rs, input logic [10:0] top, input logic [2:0] f);
      @(posedge clk_i);
      v <= f[2];
      ep <= f[1];
      ee <= f[0];
      ins <= {top, rs, 5'h0A, op, 6'h12};
      @(posedge clk_i);
      #1;
   endtask : issue
   task ops_all;
      logic [4:0] ops [5];
      ops = '{5'h05, 5'h07, 5'h1C, 5'h1E, 5'h1D};
      for (int i = 0; i < 5; i++) begin
         issue(ops[i], 5'(i * 7 + 3), 11'h3E0, 3'h7);
         cmp(rsp, {1'b1, 5'h0A, expv(ops[i], 5'(i * 7 + 3)), 2'b00});
         cmp(sr, 72'(i * 7 + 3));
      end
   endtask : ops_all
   task refuse;
      issue(5'h05, 5'h01, 11'h7E0, 3'h7);
      cmp({rsp.wb_en, rsp.exc_reserved, rsp.exc_disabled}, 72'h0);
      issue(5'h05, 5'h02, 11'h3E1, 3'h7);
      cmp({rsp.wb_en, rsp.exc_reserved, rsp.exc_disabled}, 72'h0);
      issue(5'h1F, 5'h03, 11'h3E0, 3'h7);
      cmp({rsp.wb_en, rsp.exc_reserved, rsp.exc_disabled}, 72'h0);
   endtask : refuse
   task exc;
      issue(5'h1E, 5'h04, 11'h3E0, 3'h5);
      cmp({rsp.wb_en, rsp.exc_reserved, rsp.exc_disabled}, 72'h2);
      issue(5'h07, 5'h05, 11'h3E0, 3'h6);
      cmp({rsp.wb_en, rsp.exc_reserved, rsp.exc_disabled}, 72'h1);
      issue(5'h1D, 5'h06, 11'h3E0, 3'h3);
      cmp({rsp.wb_en, rsp.exc_reserved, rsp.exc_disabled}, 72'h0);
   endtask : exc
   task test_done;
      if (err_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (20) @(posedge clk_i);
      reset_n_i <= 1'b1;
      ops_all();
      refuse();
      exc();
      test_done();
   end
endmodule : testbench
